// ===== hdl/rses_status.sv
/*
  Receive status register bank of a two-channel serializer/deserializer.
  Assembles each channel's received bits into bytes, keeps one holding
  register per channel and records full, end-of-frame, flow violation and
  whole-byte valid flags. Assumes a host port that issues one-cycle read
  strobes with an address, a datapath that gives one strobe per bit time,
  and outside logic that owns the interrupt enables and the gap setting.
*/
`timescale 1ns/1ps
`include "rses_consts.svh"

// What this block does
// - Channel B byte load sets bit 7 when all eight bits valid, else clears.
// - Channel A byte load sets bit 3 when all eight bits valid, else clears.
// - Whole-byte valid flags never feed any interrupt request.
// - Bit 6 sets on channel B overwrite or empty read; status read clears.
// - Bit 2 sets on channel A overwrite or empty read; status read clears.
// - Bit 5 sets when channel B gap ends the frame; status read clears.
// - Bit 1 sets when channel A gap ends the frame; status read clears.
// - Bit 4 sets whenever channel B moves data into its holding register.
// - Bit 0 sets whenever channel A moves data into its holding register.
// - Three-bit gap setting; zero ends frame at first invalid bit.
// - Flags set regardless of enables; read zero outside receive mode.
module rses_status #(
  parameter int N_CH  = 2,
  parameter int LEN_W = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_rx_enable,
  input  wire logic [LEN_W-1:0] i_eof_len,
  input  wire logic [N_CH-1:0]  i_bit_stb,
  input  wire logic [N_CH-1:0]  i_bit_valid,
  input  wire logic [N_CH-1:0]  i_bit_data,
  input  wire logic             i_rd_stb,
  input  wire logic [7:0]       i_rd_addr,
  output logic                  o_rd_ack,
  output logic                  o_rd_hit,
  output logic [7:0]            o_rd_data,
  output logic [7:0]            o_irq_flags
);

  // The status layout holds exactly two channel nibbles.
  if (N_CH != 2)
  begin : g_bad_ch
    $error("rses_status supports exactly two receive channels");
  end
  if (LEN_W < 1)
  begin : g_bad_len
    $error("rses_status needs a gap length of at least one bit");
  end

  logic [7:0]          status;
  rses_pkg::rses_byte_t hold_data [N_CH];
  rses_pkg::rses_byte_t hold_mask [N_CH];

  wire                  rd_status;
  wire                  rd_data_a;
  wire                  rd_data_b;
  wire                  rd_valid_a;
  wire                  rd_valid_b;
  wire                  rd_known;
  wire [N_CH-1:0]       rd_data_ch;
  rses_pkg::rses_byte_t rd_word;

  // Address decode of the host read strobe.
  assign rd_status  = i_rd_stb && (i_rd_addr == `RSES_STATUS_ADDR);
  assign rd_data_a  = i_rd_stb && (i_rd_addr == `RSES_DATA_A_ADDR);
  assign rd_data_b  = i_rd_stb && (i_rd_addr == `RSES_DATA_B_ADDR);
  assign rd_valid_a = i_rd_stb && (i_rd_addr == `RSES_VALID_A_ADDR);
  assign rd_valid_b = i_rd_stb && (i_rd_addr == `RSES_VALID_B_ADDR);
  assign rd_known   = rd_status || rd_data_a || rd_data_b || rd_valid_a || rd_valid_b;
  assign rd_data_ch = {rd_data_b, rd_data_a};

  // Per-channel assembly, holding register and status nibble.
  for (genvar c = 0; c < N_CH; c++)
  begin : g_ch
    localparam int BASE = c * `RSES_CH_STRIDE;

    rses_pkg::rses_byte_t   asm_data;
    rses_pkg::rses_byte_t   asm_mask;
    rses_pkg::rses_bitpos_t asm_pos;
    rses_pkg::rses_byte_t   next_asm_data;
    rses_pkg::rses_byte_t   next_asm_mask;
    logic                   hold_full;
    logic                   full_evt;
    logic                   eof_evt;
    logic                   flow_evt;
    logic                   byte_ok;
    logic                   eof;
    wire                    bit_in;
    wire                    byte_done;
    wire                    flush;
    wire                    load;
    wire                    overflow;
    wire                    underflow;

    rses_gap #(
      .LEN_W    (LEN_W)
    ) u_gap (
      .i_clk    (i_clk),
      .i_resetn (i_resetn),
      .i_enable (i_rx_enable),
      .i_stb    (i_bit_stb[c]),
      .i_valid  (i_bit_valid[c]),
      .i_len    (i_eof_len),
      .o_eof    (eof)
    );

    // Valid bits fill the byte low bit first; the eighth completes it.
    assign bit_in    = i_rx_enable && i_bit_stb[c] && i_bit_valid[c];
    assign byte_done = bit_in && (asm_pos == 3'h7);
    assign flush     = eof && (asm_mask != `RSES_BYTE_RESET);
    assign load      = byte_done || flush;
    // A load while the host empties the register is not an overwrite.
    assign overflow  = load && hold_full && !rd_data_ch[c];
    assign underflow = i_rx_enable && rd_data_ch[c] && !hold_full;

    // Byte under assembly with the incoming bit merged in.
    always_comb
    begin
      next_asm_data = asm_data;
      next_asm_mask = asm_mask;
      if (bit_in)
      begin
        next_asm_data[asm_pos] = i_bit_data[c];
        next_asm_mask[asm_pos] = 1'b1;
      end
    end

    // Assembly restarts after each load and outside receive mode.
    always_ff @(posedge i_clk)
    begin
      if (!i_resetn || !i_rx_enable || load)
      begin
        asm_data <= `RSES_BYTE_RESET;
        asm_mask <= `RSES_BYTE_RESET;
        asm_pos  <= '0;
      end
      else if (bit_in)
      begin
        asm_data <= next_asm_data;
        asm_mask <= next_asm_mask;
        asm_pos  <= asm_pos + 1'b1;
      end
    end

    // Holding register fills on a load and empties when the host reads it.
    always_ff @(posedge i_clk)
    begin
      if (!i_resetn || !i_rx_enable)
      begin
        hold_full    <= 1'b0;
        hold_data[c] <= `RSES_BYTE_RESET;
        hold_mask[c] <= `RSES_BYTE_RESET;
      end
      else if (load)
      begin
        hold_full    <= 1'b1;
        hold_data[c] <= next_asm_data;
        hold_mask[c] <= next_asm_mask;
      end
      else if (rd_data_ch[c])
      begin
        hold_full <= 1'b0;
      end
    end

    // Event flags: a new event wins over the clearing status read.
    always_ff @(posedge i_clk)
    begin
      if (!i_resetn || !i_rx_enable)
      begin
        full_evt <= 1'b0;
        eof_evt  <= 1'b0;
        flow_evt <= 1'b0;
        byte_ok  <= 1'b0;
      end
      else
      begin
        full_evt <= load || (full_evt && !rd_status);
        eof_evt  <= eof || (eof_evt && !rd_status);
        flow_evt <= overflow || underflow || (flow_evt && !rd_status);
        if (load)
        begin
          byte_ok <= (next_asm_mask == `RSES_ALL_VALID);
        end
      end
    end

    // Channel nibble of the status register.
    assign status[BASE + `RSES_FULL_BIT]  = full_evt;
    assign status[BASE + `RSES_EOF_BIT]   = eof_evt;
    assign status[BASE + `RSES_FLOW_BIT]  = flow_evt;
    assign status[BASE + `RSES_VALID_BIT] = byte_ok;

    // Interrupt sources for the outside enable logic, valid flag withheld.
    assign o_irq_flags[BASE + `RSES_FULL_BIT]  = full_evt;
    assign o_irq_flags[BASE + `RSES_EOF_BIT]   = eof_evt;
    assign o_irq_flags[BASE + `RSES_FLOW_BIT]  = flow_evt;
    assign o_irq_flags[BASE + `RSES_VALID_BIT] = 1'b0;
  end

  // Read data selection; everything reads zero outside receive mode.
  assign rd_word = !i_rx_enable ? `RSES_BYTE_RESET :
                   rd_status    ? status :
                   rd_data_a    ? hold_data[0] :
                   rd_valid_a   ? hold_mask[0] :
                   rd_data_b    ? hold_data[1] :
                   rd_valid_b   ? hold_mask[1] :
                   `RSES_BYTE_RESET;

  // Read answer registered one cycle after the strobe.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_rd_ack  <= 1'b0;
      o_rd_hit  <= 1'b0;
      o_rd_data <= `RSES_STATUS_RESET;
    end
    else
    begin
      o_rd_ack  <= i_rd_stb;
      o_rd_hit  <= rd_known;
      o_rd_data <= i_rd_stb ? rd_word : `RSES_STATUS_RESET;
    end
  end

endmodule : rses_status

// ===== hdl/rses_consts.svh
/*
  Register offsets, status bit positions and reset values of the receive
  status block. Assumes it is included by bare name from the design files.
*/
`ifndef RSES_CONSTS_SVH
`define RSES_CONSTS_SVH

// Byte addresses of the receive registers on the host serial port.
`define RSES_STATUS_ADDR  8'h08
`define RSES_DATA_A_ADDR  8'h09
`define RSES_VALID_A_ADDR 8'h0a
`define RSES_DATA_B_ADDR  8'h0b
`define RSES_VALID_B_ADDR 8'h0c

// Position of each flag inside a channel nibble; channel B adds four.
`define RSES_FULL_BIT  0
`define RSES_EOF_BIT   1
`define RSES_FLOW_BIT  2
`define RSES_VALID_BIT 3
`define RSES_CH_STRIDE 4

// Reset values and the all-valid byte mask.
`define RSES_STATUS_RESET 8'h00
`define RSES_BYTE_RESET   8'h00
`define RSES_ALL_VALID    8'hff

`endif

// ===== hdl/rses_pkg.sv
/*
  Types shared by the receive status block. Assumes nothing beyond a
  SystemVerilog compiler; constants live in rses_consts.svh.
*/
package rses_pkg;

  // One received byte or one byte of valid flags.
  typedef logic [7:0] rses_byte_t;

  // Bit position inside the byte being assembled.
  typedef logic [2:0] rses_bitpos_t;

endpackage : rses_pkg

// ===== hdl/rses_gap.sv
/*
  End-of-frame gap detector for one receive channel. Assumes one strobe per
  bit time, inputs synchronous to i_clk, and a steady gap length setting.
*/
`timescale 1ns/1ps

module rses_gap #(
  parameter int LEN_W = 3
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_enable,
  input  wire logic             i_stb,
  input  wire logic             i_valid,
  input  wire logic [LEN_W-1:0] i_len,
  output logic                  o_eof
);

  logic             started;
  logic [LEN_W-1:0] gap_cnt;
  wire              bad_bit;

  // An invalid bit time counts only once a valid bit has opened the frame.
  assign bad_bit = i_enable && i_stb && !i_valid && started;

  // The frame ends when the gap exceeds the setting; zero ends it at once.
  assign o_eof = bad_bit && (gap_cnt == i_len);

  // Gap counter restarts on every valid bit and closes the frame at its end.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || !i_enable)
    begin
      started <= 1'b0;
      gap_cnt <= '0;
    end
    else if (i_stb && i_valid)
    begin
      started <= 1'b1;
      gap_cnt <= '0;
    end
    else if (o_eof)
    begin
      started <= 1'b0;
      gap_cnt <= '0;
    end
    else if (bad_bit)
    begin
      gap_cnt <= gap_cnt + 1'b1;
    end
  end

endmodule : rses_gap

// ===== bench/rses_host.sv
/*
  Host model that issues register reads to the receive status block.
  Assumes an answer one cycle after each one-cycle read strobe.
*/
`timescale 1ns/1ps

module rses_host (
  input  wire logic       i_clk,
  input  wire logic       i_rd_ack,
  input  wire logic [7:0] i_rd_data,
  output logic            o_rd_stb = 1'b0,
  output logic [7:0]      o_rd_addr = 8'h00
);
  // One strobe, then a bounded wait for the acknowledge.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int n;
    @(posedge i_clk);
    o_rd_stb  <= 1'b1;
    o_rd_addr <= a;
    @(posedge i_clk);
    o_rd_stb <= 1'b0;
    for (n = 0; n < 4 && i_rd_ack !== 1'b1; n++) @(posedge i_clk);
    d = i_rd_data;
  endtask : rd
endmodule : rses_host

// ===== bench/rses_status_asserts.sv
/*
  Checker of the receive status block.
  Assumes it is bound to rses_status and sees only its ports.
*/
`timescale 1ns/1ps

module rses_status_asserts #(
  parameter int N_CH  = 2,
  parameter int LEN_W = 3
) (
  input wire logic             i_clk,
  input wire logic             i_resetn,
  input wire logic             i_rx_enable,
  input wire logic [LEN_W-1:0] i_eof_len,
  input wire logic [N_CH-1:0]  i_bit_stb,
  input wire logic [N_CH-1:0]  i_bit_valid,
  input wire logic             i_rd_stb,
  input wire logic [7:0]       i_rd_addr,
  input wire logic             o_rd_ack,
  input wire logic             o_rd_hit,
  input wire logic [7:0]       o_rd_data,
  input wire logic [7:0]       o_irq_flags
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  logic st_rd;
  // Status read with receive enabled.
  assign st_rd = i_rd_stb && i_rd_addr == 8'h08 && i_rx_enable;

  property p_quiet; !o_irq_flags[7] && !o_irq_flags[3]; endproperty
  a_quiet: assert property (p_quiet) else $error("valid flag on irq");
  property p_off; !i_rx_enable |=> o_irq_flags == 8'h00 && o_rd_data == 8'h00; endproperty
  a_off: assert property (p_off) else $error("status not zero off");
  property p_clear; st_rd && i_bit_stb == 2'b00 |=> o_irq_flags == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("read did not clear");
  property p_data; st_rd |=> (o_rd_data & 8'h77) == $past(o_irq_flags); endproperty
  a_data: assert property (p_data) else $error("status data wrong");
  property p_hit;
    i_rd_stb |=> o_rd_ack && o_rd_hit == ($past(i_rd_addr) inside {[8'h08:8'h0c]});
  endproperty
  a_hit: assert property (p_hit) else $error("read answer wrong");
  property p_idle; !i_rd_stb |=> !o_rd_ack && o_rd_data == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("answer without read");
  property p_sticky;
    i_rx_enable && !st_rd |=> (($past(o_irq_flags) & ~o_irq_flags) & 8'h77) == 8'h00;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_eof;
    i_rx_enable && i_eof_len == 3'h0 && i_bit_stb[0] && i_bit_valid[0]
      ##1 i_rx_enable && i_bit_stb[0] && !i_bit_valid[0] |=> o_irq_flags[1];
  endproperty
  a_eof: assert property (p_eof) else $error("end of frame missed");
endmodule : rses_status_asserts

// Every checker port is tied by name to the port of the same name on the block.
bind rses_status rses_status_asserts #(
  .N_CH        (N_CH),
  .LEN_W       (LEN_W)
) u_chk (
  .i_clk       (i_clk),
  .i_resetn    (i_resetn),
  .i_rx_enable (i_rx_enable),
  .i_eof_len   (i_eof_len),
  .i_bit_stb   (i_bit_stb),
  .i_bit_valid (i_bit_valid),
  .i_rd_stb    (i_rd_stb),
  .i_rd_addr   (i_rd_addr),
  .o_rd_ack    (o_rd_ack),
  .o_rd_hit    (o_rd_hit),
  .o_rd_data   (o_rd_data),
  .o_irq_flags (o_irq_flags)
);

// ===== bench/rses_status_test.sv
/*
  Self-checking bench of the receive status block.
  Assumes the host model and the bound checker.
*/
`timescale 1ns/1ps

module rses_status_test;
  logic       i_clk, rd_stb, rd_ack, rd_hit;
  logic       i_resetn = 1'b0;
  logic       i_rx_enable = 1'b1;
  logic [2:0] i_eof_len = 3'h0;
  logic [1:0] stb = 2'h0, vld = 2'h0, dat = 2'h0;
  logic [7:0] rd_addr, rd_data, irq, d;
  int         failures = 0, num_checks = 0, cyc = 0;

  rses_status i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_rx_enable(i_rx_enable),
    .i_eof_len(i_eof_len), .i_bit_stb(stb), .i_bit_valid(vld), .i_bit_data(dat),
    .i_rd_stb(rd_stb), .i_rd_addr(rd_addr), .o_rd_ack(rd_ack), .o_rd_hit(rd_hit),
    .o_rd_data(rd_data), .o_irq_flags(irq));
  rses_host i_host (.i_clk(i_clk), .i_rd_ack(rd_ack), .i_rd_data(rd_data),
    .o_rd_stb(rd_stb), .o_rd_addr(rd_addr));

  // Clock of 20 ns.
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  // Cuts a hang short.
  always @(posedge i_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      failures++;
      report_and_stop();
    end
  end

  task automatic chk(input string n, input logic [7:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Reads one register, then checks the data, the acknowledge and the map hit.
  task automatic rc(input logic [7:0] a, e);
    logic [7:0] want_ans;
    want_ans = {6'h00, 1'b1, (a >= 8'h08) && (a <= 8'h0c)};
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), d, e);
    chk("ack and hit", {6'h00, rd_ack, rd_hit}, want_ans);
  endtask : rc

  // Sends n bit times; valid and data come bit by bit from the vectors.
  task automatic bits(input logic [1:0] s, input logic [7:0] va, vb, a, b, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk);
      stb <= s;
      vld <= {vb[i], va[i]};
      dat <= {b[i], a[i]};
    end
    @(posedge i_clk);
    stb <= 2'b00;
  endtask : bits

  task report_and_stop;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Reset, then the scenarios in order.
  initial
  begin
    repeat (6) @(posedge i_clk);
    i_resetn <= 1'b1;
    rc(8'h08, 8'h00);
    rc(8'h0a, 8'h00);
    rc(8'h20, 8'h00);
    rc(8'h09, 8'h00);
    rc(8'h0b, 8'h00);
    rc(8'h08, 8'h44);
    rc(8'h08, 8'h00);
    bits(2'h3, 8'hff, 8'hff, 8'ha5, 8'h3c, 8);
    @(posedge i_clk);
    chk("irq flags", irq, 8'h11);
    rc(8'h08, 8'h99);
    rc(8'h09, 8'ha5);
    rc(8'h0b, 8'h3c);
    rc(8'h0c, 8'hff);
    bits(2'h3, 8'hff, 8'hff, 8'h5a, 8'hc3, 8);
    bits(2'h3, 8'hff, 8'hff, 8'h0f, 8'hf0, 8);
    rc(8'h08, 8'hdd);
    rc(8'h09, 8'h0f);
    rc(8'h0b, 8'hf0);
    fork
      bits(2'h3, 8'hff, 8'hff, 8'h11, 8'h22, 8);
      begin
        repeat (7) @(posedge i_clk);
        rc(8'h08, 8'h88);
      end
    join
    rc(8'h08, 8'h99);
    rc(8'h09, 8'h11);
    rc(8'h0b, 8'h22);
    bits(2'h1, 8'h07, 8'h00, 8'h05, 8'h00, 4);
    rc(8'h08, 8'h83);
    rc(8'h0a, 8'h07);
    i_eof_len <= 3'h2;
    bits(2'h2, 8'h00, 8'h07, 8'h00, 8'h06, 5);
    rc(8'h08, 8'h80);
    bits(2'h2, 8'h00, 8'h00, 8'h00, 8'h00, 1);
    rc(8'h08, 8'h30);
    rc(8'h0c, 8'h07);
    rc(8'h0b, 8'h06);
    i_rx_enable <= 1'b0;
    bits(2'h3, 8'hff, 8'hff, 8'hff, 8'hff, 8);
    rc(8'h08, 8'h00);
    i_rx_enable <= 1'b1;
    rc(8'h08, 8'h00);
    rc(8'h0c, 8'h00);
    report_and_stop();
  end
endmodule : rses_status_test
